// ===== ccen_map.svh
// register offsets, field positions and reset values of the channel enable block
`ifndef CCEN_MAP_SVH
`define CCEN_MAP_SVH
`define CCEN_ADDR_CHAN_EN      8'h20
`define CCEN_ADDR_OUT_CTRL     8'h30
`define CCEN_ADDR_CHAN_SEL     8'h34
`define CCEN_ADDR_STATUS       8'h38
`define CCEN_RESET             32'h0000_0000
`define CCEN_WRITE_MASK        32'h0033_3FFF
`define CCEN_POL_MASK          32'h0022_2AAA
`define CCEN_OUT_CTRL_MASK     32'h0000_01FF
`define CCEN_CHAN_SEL_MASK     32'h0000_0FFF
`define CCEN_OUT_MOE_BIT       0
`define CCEN_OUT_IDLE_OFF_STATE_SELECT_BIT      1
`define CCEN_OUT_RUN_OFF_STATE_SELECT_BIT      2
`define CCEN_OUT_IDLE_LSB      3
`define CCEN_OUT_LOCK_LSB      7
`define CCEN_SEL_OUTPUT        2'h0
`endif

// ===== ccen_pkg.sv
// types of the capture/compare channel enable block
package ccen_pkg;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;
  typedef struct packed {
    logic main_en;
    logic main_pol;
    logic comp_en;
    logic comp_pol;
  } chan_cfg_t;
  typedef struct packed {
    logic level;
    logic enable;
  } pin_drive_t;
  typedef enum logic [2:0] {
    OUT_OFF  = 3'h1,
    OUT_IDLE = 3'h2,
    OUT_RUN  = 3'h4
  } out_state_t;
endpackage

// ===== ccen_out_pair.sv
// output level and enable of one main/complementary channel pair
`timescale 1ns/1ps
`include "ccen_map.svh"
module ccen_out_pair
  import ccen_pkg::*;
(
  input  wire logic       moe,
  input  wire logic       idle_off_state_select,
  input  wire logic       run_off_state_select,
  input  wire logic       idle_main,
  input  wire logic       idle_comp,
  input  wire logic       ref_in,
  input  wire logic       has_comp,
  input  wire chan_cfg_t  cfg,
  output pin_drive_t      main_out,
  output pin_drive_t      comp_out
);
  logic cen;
  assign cen = cfg.comp_en & has_comp;
  // [RULE3] joint output table
  always_comb begin
    main_out = '0;
    comp_out = '0;
    if (moe) begin
      // [RULE16] [RULE4] [RULE8] polarity xor
      if (cfg.main_en) begin
        main_out.level  = cen ? ref_in ^ cfg.main_pol : ref_in ^ cfg.main_pol;
        main_out.enable = 1'b1;
      end else if (run_off_state_select && cen) begin
        main_out.level  = cfg.main_pol;
        main_out.enable = 1'b1;
      end else begin
        main_out.level  = run_off_state_select ? cfg.main_pol : 1'b0;
        main_out.enable = 1'b0;
      end
      // [RULE1] [RULE2] complementary gating
      if (cen) begin
        comp_out.level  = cfg.main_en ? ~ref_in ^ cfg.comp_pol : ref_in ^ cfg.comp_pol;
        comp_out.enable = 1'b1;
      end else if (run_off_state_select && cfg.main_en && has_comp) begin
        comp_out.level  = cfg.comp_pol;
        comp_out.enable = 1'b1;
      end else begin
        comp_out.level  = run_off_state_select ? cfg.comp_pol : 1'b0;
        comp_out.enable = 1'b0;
      end
    end else begin
      // idle: off-state, then idle levels
      if (cfg.main_en | cen) begin
        main_out.level = idle_main;
        comp_out.level = idle_comp & has_comp;
      end else begin
        main_out.level = cfg.main_pol;
        comp_out.level = cfg.comp_pol & has_comp;
      end
      main_out.enable = idle_off_state_select;
      comp_out.enable = idle_off_state_select & has_comp;
    end
  end
endmodule

// ===== ccen_capture_edge.sv
// synchronised capture input with polarity-selected edge detect
`timescale 1ns/1ps
module ccen_capture_edge (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  input  wire logic pol,
  input  wire logic enable,
  output logic      trig,
  output logic      capture
);
  logic sync1;
  logic sync2;
  logic last;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last  <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      last  <= sync2;
    end
  end
  // [RULE6] trigger inverted by polarity
  assign trig = sync2 ^ pol;
  // [RULE5] [RULE9] edge choice and capture gate
  assign capture = enable & (pol ? (last & ~sync2) : (~last & sync2));
endmodule

// ===== ccen_top.sv
// capture/compare channel enable and polarity control with register port
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "ccen_map.svh"
//////////////////////////////////////////////////////////////////////////////
// Operation
// [RULE1] complementary polarity bit 3: 0 active high, 1 active low
// [RULE2] complementary enable bit 2 turns the complementary output on
// [RULE3] pin level set by main enable, off-state selects, idle levels, enables
// [RULE4] output mode: main polarity bit 1 inverts main output when set
// [RULE5] input mode: polarity 0 captures rising edge, 1 falling edge
// [RULE6] input used as trigger is inverted when polarity is set
// [RULE7] polarity writes ignored while lock level is 3 or 2
// [RULE8] output mode: enable bit 0 turns the main output on
// [RULE9] input mode: enable bit switches capture on or off
// [RULE10] channels 2 and 3 repeat channel 1 at bits 4-7 and 8-11
// [RULE11] channels 4,5,6 have enable/polarity at bits 12-13, 16-17, 20-21
// [RULE12] software keeps reserved bits at reset value
// [RULE13] all enable and polarity bits reset to zero
// [RULE14] selection code 00 means output, other codes mean input
// [RULE15] software changes selection only while channel is disabled
// [RULE16] lone main output drives reference xor main polarity
// [RULE17] unused channel: software clears idle levels and polarities
module ccen_top
  import ccen_pkg::*;
#(
  parameter int NUM_CH = 6
)
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic [5:0]  COMPARE_REF,
  input  wire logic [5:0]  CAPTURE_IN,
  output logic      [5:0]  MAIN_OUT,
  output logic      [5:0]  MAIN_OUT_EN,
  output logic      [2:0]  COMP_OUT,
  output logic      [2:0]  COMP_OUT_EN,
  output logic      [5:0]  CAPTURE_STROBE,
  output logic      [5:0]  TRIGGER_OUT
);
  if (NUM_CH != 6) begin : gen_bad_ch
    $error("ccen_top supports exactly six channels");
  end

  //////////////////////////////////////////////////////////////////////////////
  bus_req_t   req;
  logic [31:0] chan_en;
  logic [8:0]  out_ctrl;
  logic [11:0] chan_sel;
  logic [5:0]  is_output;
  logic [5:0]  cap_now;
  logic [5:0]  trig_now;
  logic [5:0]  cap_seen;
  logic [5:0]  next_main;
  logic [5:0]  next_main_en;
  logic [2:0]  next_comp;
  logic [2:0]  next_comp_en;
  logic [1:0]  lock;
  logic        locked;
  chan_cfg_t  cfg [6];

  assign req    = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign lock   = out_ctrl[`CCEN_OUT_LOCK_LSB +: 2];
  assign locked = (lock == 2'h3) || (lock == 2'h2);

  // bit position of a channel's enable; its polarity sits one above
  function automatic int pair_base(input int ch);
    return (ch < 3) ? ch * 4 : 12 + (ch - 3) * 4;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // enable/polarity register
  always_ff @(posedge CLK_SYS or posedge RST) begin
    // [RULE13] reset clears all
    if (RST) begin
      chan_en <= `CCEN_RESET;
    end else if (req.wr && req.addr == `CCEN_ADDR_CHAN_EN) begin
      // [RULE7] polarity lock
      if (locked)
        chan_en <= (req.wdata & `CCEN_WRITE_MASK & ~`CCEN_POL_MASK) | (chan_en & `CCEN_POL_MASK);
      else
        chan_en <= req.wdata & `CCEN_WRITE_MASK;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      out_ctrl <= '0;
    end else if (req.wr && req.addr == `CCEN_ADDR_OUT_CTRL) begin
      out_ctrl <= req.wdata[8:0];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      chan_sel <= '0;
    end else if (req.wr && req.addr == `CCEN_ADDR_CHAN_SEL) begin
      // selection field of a channel changes only while it is disabled
      for (int i = 0; i < 6; i++) begin
        if (!chan_en[pair_base(i)])
          chan_sel[i*2 +: 2] <= req.wdata[i*2 +: 2];
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cap_seen <= '0;
    end else begin
      // set wins over the read-clear
      if (req.rd && req.addr == `CCEN_ADDR_STATUS)
        cap_seen <= cap_now;
      else
        cap_seen <= cap_seen | cap_now;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RDATA <= '0;
    end else if (req.rd) begin
      case (req.addr)
        `CCEN_ADDR_CHAN_EN:  RDATA <= chan_en;
        `CCEN_ADDR_OUT_CTRL: RDATA <= {23'h0, out_ctrl};
        `CCEN_ADDR_CHAN_SEL: RDATA <= {20'h0, chan_sel};
        `CCEN_ADDR_STATUS:   RDATA <= {26'h0, cap_seen};
        default:             RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-channel configuration and datapath
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gen_ch
      // [RULE10] [RULE11] field placement
      assign cfg[g].main_en  = chan_en[pair_base(g)];
      assign cfg[g].main_pol = chan_en[pair_base(g) + 1];
      assign cfg[g].comp_en  = (g < 3) ? chan_en[g*4 + 2] : 1'b0;
      assign cfg[g].comp_pol = (g < 3) ? chan_en[g*4 + 3] : 1'b0;
      // [RULE14] code 00 is output
      assign is_output[g] = (chan_sel[g*2 +: 2] == `CCEN_SEL_OUTPUT);

      pin_drive_t mo;
      pin_drive_t co;
      ccen_out_pair u_pair (
        .moe       (out_ctrl[`CCEN_OUT_MOE_BIT]),
        .idle_off_state_select      (out_ctrl[`CCEN_OUT_IDLE_OFF_STATE_SELECT_BIT]),
        .run_off_state_select      (out_ctrl[`CCEN_OUT_RUN_OFF_STATE_SELECT_BIT]),
        .idle_main (g == 0 ? out_ctrl[`CCEN_OUT_IDLE_LSB] : (g == 1 ? out_ctrl[`CCEN_OUT_IDLE_LSB + 2] : 1'b0)),
        .idle_comp (g == 0 ? out_ctrl[`CCEN_OUT_IDLE_LSB + 1] : (g == 1 ? out_ctrl[`CCEN_OUT_IDLE_LSB + 3] : 1'b0)),
        .ref_in    (COMPARE_REF[g]),
        .has_comp  (g < 3 ? 1'b1 : 1'b0),
        .cfg       (cfg[g]),
        .main_out  (mo),
        .comp_out  (co)
      );
      assign next_main[g]    = is_output[g] & mo.level;
      assign next_main_en[g] = is_output[g] & mo.enable;
      if (g < 3) begin : gen_comp
        assign next_comp[g]    = is_output[g] & co.level;
        assign next_comp_en[g] = is_output[g] & co.enable;
      end

      ccen_capture_edge u_cap (
        .clk     (CLK_SYS),
        .rst     (RST),
        .pin     (CAPTURE_IN[g]),
        .pol     (cfg[g].main_pol),
        .enable  (cfg[g].main_en & ~is_output[g]),
        .trig    (trig_now[g]),
        .capture (cap_now[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      MAIN_OUT    <= '0;
      MAIN_OUT_EN <= '0;
      COMP_OUT    <= '0;
      COMP_OUT_EN <= '0;
    end else begin
      MAIN_OUT    <= next_main;
      MAIN_OUT_EN <= next_main_en;
      COMP_OUT    <= next_comp;
      COMP_OUT_EN <= next_comp_en;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      CAPTURE_STROBE <= '0;
      TRIGGER_OUT    <= '0;
    end else begin
      CAPTURE_STROBE <= cap_now;
      TRIGGER_OUT    <= trig_now & ~is_output;
    end
  end
endmodule

// ===== ccen_top_properties.sv
// port-level checks of the channel enable block and its bind
`timescale 1ns/1ps
`include "ccen_map.svh"
module ccen_checker (
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic [5:0]  COMPARE_REF,
  input wire logic [5:0]  CAPTURE_IN,
  input wire logic [5:0]  MAIN_OUT,
  input wire logic [5:0]  MAIN_OUT_EN,
  input wire logic [2:0]  COMP_OUT,
  input wire logic [2:0]  COMP_OUT_EN,
  input wire logic [5:0]  CAPTURE_STROBE,
  input wire logic [5:0]  TRIGGER_OUT
);
  logic [31:0] en;
  logic [31:0] pm;
  logic [8:0]  ctl;
  logic [1:0]  sel;
  logic        run;
  // shadow of the registers, polarity kept while locked
  assign pm = ctl[8] ? `CCEN_POL_MASK : 32'h0;
  assign run = ctl[0] && sel == 2'h0 && !WR;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      en <= 32'h0;
      ctl <= 9'h0;
      sel <= 2'h0;
    end else if (WR) begin
      if (ADDR == `CCEN_ADDR_CHAN_EN) en <= (WDATA & `CCEN_WRITE_MASK & ~pm) | (en & pm);
      if (ADDR == `CCEN_ADDR_OUT_CTRL) ctl <= WDATA[8:0];
      if (ADDR == `CCEN_ADDR_CHAN_SEL && !en[0]) sel <= WDATA[1:0];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  reg_readback_a: assert property ($past(RD) && $past(ADDR) == `CCEN_ADDR_CHAN_EN |-> RDATA == $past(en))
    else $error("register readback wrong");
  reset_clear_a: assert property ($fell(RST) |-> MAIN_OUT_EN == 6'h00 && COMP_OUT_EN == 3'h0)
    else $error("outputs live after reset");
  lone_main_a: assert property (run && en[0] && !en[2] |=> MAIN_OUT_EN[0] && MAIN_OUT[0] == $past(COMPARE_REF[0] ^ en[1]))
    else $error("main output wrong");
  comp_lone_a: assert property (run && !ctl[2] && !en[0] && en[2] |=> !MAIN_OUT_EN[0] && COMP_OUT_EN[0] && COMP_OUT[0] == $past(COMPARE_REF[0] ^ en[3]))
    else $error("comp output wrong");
  both_off_a: assert property (run && !ctl[2] && !en[0] && !en[2] |=> MAIN_OUT_EN[0] == 1'b0 && COMP_OUT_EN[0] == 1'b0)
    else $error("disabled pair driven");
  trig_output_a: assert property (sel == 2'h0 && !WR |=> TRIGGER_OUT[0] == 1'b0)
    else $error("trigger in output mode");
  capture_off_a: assert property ((!en[0]) [*5] |-> CAPTURE_STROBE[0] == 1'b0)
    else $error("capture while disabled");
  trig_level_a: assert property ((sel != 2'h0 && $stable(CAPTURE_IN[0]) && $stable(en[1])) [*5] |-> TRIGGER_OUT[0] == (CAPTURE_IN[0] ^ en[1]))
    else $error("trigger level wrong");
  cover property (run && en[0] && !en[2]);
  cover property (CAPTURE_STROBE[0]);
  cover property (WR && ctl[8] && ADDR == `CCEN_ADDR_CHAN_EN);
endmodule
bind ccen_top ccen_checker u_chk (.CLK_SYS, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .COMPARE_REF, .CAPTURE_IN,
  .MAIN_OUT, .MAIN_OUT_EN, .COMP_OUT, .COMP_OUT_EN, .CAPTURE_STROBE, .TRIGGER_OUT);

// ===== ccen_pin_model.sv
// external capture signal source, moving off the timer clock phase
`timescale 1ns/1ps
module ccen_pin_model (
  input  wire logic [5:0] level_req,
  output logic      [5:0] pin
);
  initial pin = 6'h00;
  always @(level_req) pin <= #7 level_req;
endmodule

// ===== ccen_top_tb.sv
// self-checking bench of the channel enable block
`timescale 1ns/1ps
`include "ccen_map.svh"
module ccen_top_tb;
  typedef struct packed {
    logic [31:0] en;
    logic [8:0]  ctl;
    logic [5:0]  rf;
    logic [5:0]  mo;
    logic [5:0]  moe;
    logic [2:0]  co;
    logic [2:0]  coe;
  } row_t;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [5:0]  cref = 6'h00, creq = 6'h00, cin, mo, moe, strb, trig;
  logic [2:0]  co, coe;
  int          mismatches = 0, total_checks = 0, n;
  // first row leaves unused channels with idle and polarity bits clear
  row_t        rows [7] = '{'{32'h0, 9'h1, 6'h3F, 6'h00, 6'h00, 3'h0, 3'h0},
    '{32'h00131311, 9'h1, 6'h3F, 6'h2B, 6'h3F, 3'h0, 3'h0}, '{32'h4C4, 9'h1, 6'h05, 6'h00, 6'h00, 3'h7, 3'h7},
    '{32'h00131311, 9'h0, 6'h3F, 6'h00, 6'h00, 3'h0, 3'h0}, '{32'h00131311, 9'hA, 6'h3F, 6'h01, 6'h3F, 3'h0, 3'h7},
    '{32'h3, 9'h5, 6'h00, 6'h01, 6'h01, 3'h0, 3'h1}, '{32'hF, 9'h1, 6'h01, 6'h00, 6'h01, 3'h1, 3'h1}};
  // capture rows: polarity, enable, pin level, expected strobes
  logic [3:0]  caps [7] = '{4'h7, 4'h4, 4'h2, 4'hD, 4'hE, 4'h8, 4'hA};
  ccen_top DUT (.CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .COMPARE_REF(cref), .CAPTURE_IN(cin), .MAIN_OUT(mo), .MAIN_OUT_EN(moe), .COMP_OUT(co),
    .COMP_OUT_EN(coe), .CAPTURE_STROBE(strb), .TRIGGER_OUT(trig));
  ccen_pin_model u_pins (.level_req(creq), .pin(cin));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, rdata, exp);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr_reg(`CCEN_ADDR_OUT_CTRL, {23'h0, rows[i].ctl});
      wr_reg(`CCEN_ADDR_CHAN_EN, rows[i].en);
      cref <= rows[i].rf;
      repeat (3) @(posedge clk);
      #1 chk("main level", 32'(mo), 32'(rows[i].mo));
      chk("main enable", 32'(moe), 32'(rows[i].moe));
      chk("comp level", 32'(co), 32'(rows[i].co));
      chk("comp enable", 32'(coe), 32'(rows[i].coe));
      rd_reg(`CCEN_ADDR_CHAN_EN, rows[i].en, "enable reg");
    end
    wr_reg(`CCEN_ADDR_CHAN_EN, 32'h0);
    wr_reg(`CCEN_ADDR_CHAN_SEL, 32'h1);
    foreach (caps[i]) begin
      wr_reg(`CCEN_ADDR_CHAN_EN, {30'h0, caps[i][3:2]});
      creq[0] <= caps[i][1];
      n = 0;
      repeat (12) @(posedge clk) n += strb[0];
      chk("strobes", 32'(n), 32'(caps[i][0]));
      chk("trigger", 32'(trig[0]), 32'(caps[i][1] ^ caps[i][3]));
    end
    rd_reg(`CCEN_ADDR_CHAN_SEL, 32'h1, "selection");
    rd_reg(`CCEN_ADDR_STATUS, 32'h1, "capture seen");
    rd_reg(`CCEN_ADDR_STATUS, 32'h0, "seen cleared");
    rd_reg(8'h3C, 32'h0, "unmapped");
    for (int lk = 0; lk < 4; lk++) begin
      wr_reg(`CCEN_ADDR_OUT_CTRL, 32'(lk) << 7);
      wr_reg(`CCEN_ADDR_CHAN_EN, `CCEN_WRITE_MASK);
      rd_reg(`CCEN_ADDR_CHAN_EN, lk > 1 ? `CCEN_WRITE_MASK & ~`CCEN_POL_MASK : `CCEN_WRITE_MASK, "lock");
      wr_reg(`CCEN_ADDR_CHAN_EN, 32'h0);
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("outputs", {14'h0, mo, moe, co, coe}, 32'h0);
    rd_reg(`CCEN_ADDR_OUT_CTRL, 32'h0, "reset ctrl");
    end_of_test();
  end
endmodule
